// file: rtl/efol_encoder_feedback.sv
/*
  Encoder feedback and regenerated quadrature output with APB registers,
  plus auxiliary encoder decoder.
  Assumes all encoder inputs synchronous to pclk and a digitised in-cycle
  phase from the sine/cosine front end.
*/
module efol_encoder_feedback #(
  parameter int unsigned UPD_CYC = efol_pkg::EFOL_UPD_CYC
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [efol_pkg::EFOL_ADDR_W-1:0]  paddr,
  input  wire logic [efol_pkg::EFOL_DATA_W-1:0]  pwdata,
  output logic      [efol_pkg::EFOL_DATA_W-1:0]  prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           motor_enc_chan_a,
  input  wire logic                           motor_enc_chan_b,
  input  wire logic [efol_pkg::EFOL_PHASE_W-1:0] sincos_phase,
  input  wire logic                           aux_enc_chan_a,
  input  wire logic                           aux_enc_chan_b,
  input  wire logic                           aux_enc_index,
  input  wire logic                           net_variant,
  output logic                                unbuf_chan_a,
  output logic                                unbuf_chan_b,
  output logic                                regen_out_chan_a,
  output logic                                regen_out_chan_b,
  output logic      [efol_pkg::EFOL_POS_W-1:0]   loop_position
);
  import efol_pkg::*;

  localparam int unsigned TW = $clog2(UPD_CYC);

  efol_apb_st_t            apb_st, next_apb_st;
  efol_out_mode_t          out_mode, eff_mode;
  efol_aux_mode_t          aux_mode;
  logic                    sincos, next_sincos, next_pready, next_pslverr, rd_ok;
  logic [3:0]              interp_k, div_k, next_interp_k, next_div_k;
  logic [1:0]              next_out_mode, next_aux_mode;
  logic [EFOL_DATA_W-1:0]  next_prdata, rd_val;
  logic                    m_up, m_dn, x_up, x_dn, filt_a, filt_b;
  logic [EFOL_POS_W-1:0]   motor_cnt, aux_cnt, aux_idx, target, gen_pos;
  logic [EFOL_POS_W-1:0]   fb_pos, src_pos, diff;
  logic [EFOL_POS_W-1:0]   next_motor_cnt, next_aux_cnt, next_aux_idx, next_target, next_gen_pos;
  logic [TW-1:0]           tick_cnt, next_tick_cnt;
  logic [2:0]              pace_cnt, next_pace_cnt;
  logic                    tick, aux_pa, aux_pb, idx_p, aux_up, aux_dn;
  logic                    next_regen_a, next_regen_b;

  efol_quad_dec u_motor_dec (
    .pclk    (pclk),
    .presetn (presetn),
    .chan_a  (motor_enc_chan_a),
    .chan_b  (motor_enc_chan_b),
    .cnt_up  (m_up),
    .cnt_dn  (m_dn)
  );

  efol_quad_dec u_aux_dec (
    .pclk    (pclk),
    .presetn (presetn),
    .chan_a  (aux_enc_chan_a),
    .chan_b  (aux_enc_chan_b),
    .cnt_up  (x_up),
    .cnt_dn  (x_dn)
  );

  efol_glitch_filt #(.DEPTH(EFOL_FILT_DEPTH)) u_filt_a (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (motor_enc_chan_a),
    .dout    (filt_a)
  );

  efol_glitch_filt #(.DEPTH(EFOL_FILT_DEPTH)) u_filt_b (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (motor_enc_chan_b),
    .dout    (filt_b)
  );

  // Register file and APB slave
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = '0;
    case (paddr)
      EFOL_ADDR_CTRL:   rd_val = {27'h0, aux_mode, sincos, out_mode};
      EFOL_ADDR_INTERP: rd_val = {28'h0, interp_k};
      EFOL_ADDR_DIV:    rd_val = {28'h0, div_k};
      EFOL_ADDR_MPOS:   rd_val = motor_cnt;
      EFOL_ADDR_APOS:   rd_val = aux_cnt;
      EFOL_ADDR_STAT:   rd_val = {29'h0, eff_mode, net_variant};
      EFOL_ADDR_AIDX:   rd_val = aux_idx;
      default:          rd_ok  = 1'b0;
    endcase
    next_apb_st   = apb_st;
    next_prdata   = prdata;
    next_pready   = 1'b0;
    next_pslverr  = 1'b0;
    next_out_mode = out_mode;
    next_sincos   = sincos;
    next_aux_mode = aux_mode;
    next_interp_k = interp_k;
    next_div_k    = div_k;
    case (apb_st)
      EFOL_APB_IDLE: begin
        if (psel && !penable) begin
          next_apb_st  = EFOL_APB_ACC;
          next_pready  = 1'b1;
          next_pslverr = !rd_ok;
          next_prdata  = (rd_ok && !pwrite) ? rd_val : '0;
        end
      end
      EFOL_APB_ACC: begin
        next_apb_st = EFOL_APB_IDLE;
        if (psel && penable && pwrite && rd_ok) begin
          case (paddr)
            EFOL_ADDR_CTRL: begin
              next_out_mode = pwdata[EFOL_CTRL_MODE_LSB+:2];
              next_sincos   = pwdata[EFOL_CTRL_SC_BIT];
              next_aux_mode = pwdata[EFOL_CTRL_AUX_LSB+:2];
            end
            EFOL_ADDR_INTERP: begin
              // Clamped to x4 .. x1024
              if (pwdata[3:0] < EFOL_INTERP_MIN || pwdata[31:4] != '0) begin
                next_interp_k = (pwdata[31:4] != '0) ? EFOL_INTERP_MAX : EFOL_INTERP_MIN;
              end else if (pwdata[3:0] > EFOL_INTERP_MAX) begin
                next_interp_k = EFOL_INTERP_MAX;
              end else begin
                next_interp_k = pwdata[3:0];
              end
            end
            EFOL_ADDR_DIV: begin
              next_div_k = (pwdata[31:0] > {28'h0, EFOL_DIV_MAX}) ? EFOL_DIV_MAX
                                                                 : pwdata[3:0];
            end
            default: begin
            end
          endcase
        end
      end
      default: next_apb_st = EFOL_APB_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_st   <= EFOL_APB_IDLE;
      prdata   <= '0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      out_mode <= EFOL_OUT_BUF;
      sincos   <= 1'b0;
      aux_mode <= EFOL_AUX_QUAD;
      interp_k <= EFOL_INTERP_MIN;
      div_k    <= EFOL_DIV_RST;
    end else begin
      apb_st   <= next_apb_st;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
      out_mode <= efol_out_mode_t'(next_out_mode);
      sincos   <= next_sincos;
      aux_mode <= efol_aux_mode_t'(next_aux_mode);
      interp_k <= next_interp_k;
      div_k    <= next_div_k;
    end
  end

  // Position, output rate tracking and auxiliary counting
  always_comb begin
    eff_mode = out_mode;
    if (net_variant || out_mode == EFOL_OUT_BUF || !(out_mode inside {EFOL_OUT_INTERP,
        EFOL_OUT_DIV})) begin
      eff_mode = EFOL_OUT_BUF;
    end else if (out_mode == EFOL_OUT_INTERP && !sincos) begin
      eff_mode = EFOL_OUT_BUF;
    end
    // Whole cycles from the edge count, fraction from the analog phase
    fb_pos = motor_cnt;
    if (sincos) begin
      fb_pos = ((motor_cnt >> 2) << interp_k) |
               (EFOL_POS_W'(sincos_phase) >> (4'(EFOL_PHASE_W) - interp_k));
    end
    src_pos = (eff_mode == EFOL_OUT_DIV) ? (fb_pos >> div_k) : fb_pos;
    next_motor_cnt = motor_cnt + (m_up ? 32'h1 : 32'h0) - (m_dn ? 32'h1 : 32'h0);
    next_tick_cnt  = tick ? '0 : tick_cnt + TW'(1);
    next_target    = target;
    next_gen_pos   = gen_pos;
    next_pace_cnt  = (pace_cnt != 3'h0) ? pace_cnt - 3'h1 : pace_cnt;
    diff           = target - gen_pos;
    if (eff_mode == EFOL_OUT_BUF) begin
      next_target  = src_pos;
      next_gen_pos = src_pos;
    end else begin
      if (tick) begin
        next_target = src_pos;
      end
      // Edges paced to the output's top rate, one per step
      if (pace_cnt == 3'h0 && diff != '0) begin
        next_gen_pos  = diff[EFOL_POS_W-1] ? gen_pos - 32'h1 : gen_pos + 32'h1;
        next_pace_cnt = 3'(EFOL_EDGE_CYC - 1);
      end
    end
    // Buffered path is the filtered input; others a regenerated quadrature
    if (eff_mode == EFOL_OUT_BUF) begin
      next_regen_a = filt_a;
      next_regen_b = filt_b;
    end else begin
      next_regen_a = gen_pos[0] ^ gen_pos[1];
      next_regen_b = gen_pos[1];
    end
    aux_up = 1'b0;
    aux_dn = 1'b0;
    case (aux_mode)
      EFOL_AUX_QUAD: begin
        aux_up = x_up;
        aux_dn = x_dn;
      end
      EFOL_AUX_STEPDIR: begin
        aux_up = aux_enc_chan_a && !aux_pa && aux_enc_chan_b;
        aux_dn = aux_enc_chan_a && !aux_pa && !aux_enc_chan_b;
      end
      EFOL_AUX_CWCCW: begin
        aux_up = aux_enc_chan_a && !aux_pa && !aux_enc_chan_b;
        aux_dn = aux_enc_chan_b && !aux_pb && !aux_enc_chan_a;
      end
      default: begin
      end
    endcase
    next_aux_cnt = aux_cnt + (aux_up ? 32'h1 : 32'h0) - (aux_dn ? 32'h1 : 32'h0);
    next_aux_idx = (aux_enc_index && !idx_p) ? aux_cnt : aux_idx;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_cnt        <= '0;
      aux_cnt          <= '0;
      aux_idx          <= '0;
      target           <= '0;
      gen_pos          <= '0;
      tick_cnt         <= '0;
      tick             <= 1'b0;
      pace_cnt         <= 3'h0;
      aux_pa           <= 1'b0;
      aux_pb           <= 1'b0;
      idx_p            <= 1'b0;
      regen_out_chan_a <= 1'b0;
      regen_out_chan_b <= 1'b0;
      unbuf_chan_a     <= 1'b0;
      unbuf_chan_b     <= 1'b0;
      loop_position    <= '0;
    end else begin
      motor_cnt        <= next_motor_cnt;
      aux_cnt          <= next_aux_cnt;
      aux_idx          <= next_aux_idx;
      target           <= next_target;
      gen_pos          <= next_gen_pos;
      tick_cnt         <= next_tick_cnt;
      tick             <= next_tick_cnt == TW'(UPD_CYC - 1);
      pace_cnt         <= next_pace_cnt;
      aux_pa           <= aux_enc_chan_a;
      aux_pb           <= aux_enc_chan_b;
      idx_p            <= aux_enc_index;
      regen_out_chan_a <= next_regen_a;
      regen_out_chan_b <= next_regen_b;
      unbuf_chan_a     <= motor_enc_chan_a;
      unbuf_chan_b     <= motor_enc_chan_b;
      loop_position    <= fb_pos;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_UNBUF_PASS: assert property (
    ##1 (unbuf_chan_a == $past(motor_enc_chan_a) && unbuf_chan_b == $past(motor_enc_chan_b)))
    else $error("unbuffered output differs from input");
  AST_BUF_COPY: assert property (
    (eff_mode == EFOL_OUT_BUF && $stable(motor_enc_chan_a))[*4] |->
      regen_out_chan_a == motor_enc_chan_a)
    else $error("buffered output not following input");
  AST_NET_BUF: assert property (
    (net_variant && $past(net_variant)) |-> regen_out_chan_b == $past(filt_b))
    else $error("network variant left buffered mode");
  AST_TGT_TICK: assert property (
    (eff_mode != EFOL_OUT_BUF && $past(eff_mode) != EFOL_OUT_BUF && $changed(target))
      |-> $past(tick))
    else $error("output target changed between intervals");
  AST_PACE: assert property (
    (eff_mode != EFOL_OUT_BUF && $past(eff_mode) != EFOL_OUT_BUF && $changed(gen_pos)) |=>
      ($stable(gen_pos) || $past(eff_mode) == EFOL_OUT_BUF) [*4])
    else $error("regenerated edges too close");
  AST_LOOP_INC: assert property (
    !sincos |=> loop_position == $past(motor_cnt))
    else $error("loop position differs from edge count");
  AST_CW_LOCK: assert property (
    (aux_mode == EFOL_AUX_CWCCW && aux_enc_chan_b) |=> aux_cnt != $past(aux_cnt) + 32'h1)
    else $error("cw pulse counted while ccw high");
  AST_STEP_UP: assert property (
    (aux_mode == EFOL_AUX_STEPDIR && $rose(aux_enc_chan_a) && aux_enc_chan_b)
      |=> aux_cnt == $past(aux_cnt) + 32'h1)
    else $error("step with direction high not counted");
  AST_INTERP_RANGE: assert property (
    interp_k >= EFOL_INTERP_MIN && interp_k <= EFOL_INTERP_MAX)
    else $error("interpolation out of range");

  COV_BUF_TOGGLE: cover property (eff_mode == EFOL_OUT_BUF ##1 $changed(regen_out_chan_a));
  COV_DIV_STEP:   cover property (eff_mode == EFOL_OUT_DIV ##1 $changed(gen_pos));
  COV_CW_COUNT:   cover property (aux_mode == EFOL_AUX_CWCCW && aux_up);
  COV_TICK:       cover property (tick && eff_mode == EFOL_OUT_INTERP);

endmodule : efol_encoder_feedback

// file: rtl/efol_pkg.sv
/*
  Shared constants for the encoder feedback output logic: register map,
  field layout, reset values, mode codes and timing counts.
  Assumes a 50 MHz APB clock.
*/
package efol_pkg;

  localparam int unsigned EFOL_CLK_PERIOD_NS = 20;
  // Regenerated output frequency refresh interval
  localparam int unsigned EFOL_UPD_US        = 250;
  localparam int unsigned EFOL_UPD_CYC       = EFOL_UPD_US * 1000 / EFOL_CLK_PERIOD_NS;
  // Highest line frequency, four edges per line
  localparam int unsigned EFOL_MAX_LINE_KHZ  = 2500;
  localparam int unsigned EFOL_EDGE_NS       = 1000000 / (4 * EFOL_MAX_LINE_KHZ);
  localparam int unsigned EFOL_EDGE_CYC      =
    (EFOL_EDGE_NS + EFOL_CLK_PERIOD_NS - 1) / EFOL_CLK_PERIOD_NS;
  localparam int unsigned EFOL_FILT_DEPTH    = 2;

  localparam int unsigned EFOL_POS_W   = 32;
  localparam int unsigned EFOL_PHASE_W = 10;
  localparam int unsigned EFOL_ADDR_W  = 8;
  localparam int unsigned EFOL_DATA_W  = 32;

  localparam logic [7:0] EFOL_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] EFOL_ADDR_INTERP = 8'h04;
  localparam logic [7:0] EFOL_ADDR_DIV    = 8'h08;
  localparam logic [7:0] EFOL_ADDR_MPOS   = 8'h0C;
  localparam logic [7:0] EFOL_ADDR_APOS   = 8'h10;
  localparam logic [7:0] EFOL_ADDR_STAT   = 8'h14;
  localparam logic [7:0] EFOL_ADDR_AIDX   = 8'h18;

  localparam int unsigned EFOL_CTRL_MODE_LSB = 0;
  localparam int unsigned EFOL_CTRL_SC_BIT   = 2;
  localparam int unsigned EFOL_CTRL_AUX_LSB  = 3;

  // Interpolation and divisor are held as powers of two
  localparam logic [3:0] EFOL_INTERP_MIN = 4'h2;
  localparam logic [3:0] EFOL_INTERP_MAX = 4'hA;
  localparam logic [3:0] EFOL_DIV_MAX    = 4'h8;
  localparam logic [3:0] EFOL_DIV_RST    = 4'h0;

  typedef enum logic [1:0] {
    EFOL_OUT_BUF    = 2'h0,
    EFOL_OUT_INTERP = 2'h1,
    EFOL_OUT_DIV    = 2'h2
  } efol_out_mode_t;

  typedef enum logic [1:0] {
    EFOL_AUX_QUAD    = 2'h0,
    EFOL_AUX_STEPDIR = 2'h1,
    EFOL_AUX_CWCCW   = 2'h2
  } efol_aux_mode_t;

  typedef enum logic [1:0] {
    EFOL_APB_IDLE = 2'b01,
    EFOL_APB_ACC  = 2'b10
  } efol_apb_st_t;

endpackage : efol_pkg

// file: rtl/efol_quad_dec.sv
/*
  Quadrature edge decoder: one up or down pulse per legal edge of either
  channel. Assumes inputs synchronous to pclk.
*/
module efol_quad_dec (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic chan_a,
  input  wire logic chan_b,
  output logic      cnt_up,
  output logic      cnt_dn
);
  import efol_pkg::*;

  logic prev_a;
  logic prev_b;
  logic next_up;
  logic next_dn;
  logic ch_a;
  logic ch_b;

  always_comb begin
    ch_a    = chan_a != prev_a;
    ch_b    = chan_b != prev_b;
    next_up = 1'b0;
    next_dn = 1'b0;
    // Both channels moving at once is dropped
    if (ch_a && !ch_b) begin
      next_up = chan_a != chan_b;
      next_dn = chan_a == chan_b;
    end else if (ch_b && !ch_a) begin
      next_up = chan_b == chan_a;
      next_dn = chan_b != chan_a;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      cnt_up <= 1'b0;
      cnt_dn <= 1'b0;
    end else begin
      prev_a <= chan_a;
      prev_b <= chan_b;
      cnt_up <= next_up;
      cnt_dn <= next_dn;
    end
  end

  AST_QD_SINGLE: assert property (@(posedge pclk) disable iff (!presetn)
    ($changed(chan_a) != $changed(chan_b)) |=> (cnt_up != cnt_dn))
    else $error("single channel edge not counted");
  AST_QD_ILLEGAL: assert property (@(posedge pclk) disable iff (!presetn)
    ($changed(chan_a) && $changed(chan_b)) |=> (!cnt_up && !cnt_dn))
    else $error("double channel edge counted");
  AST_QD_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(chan_a) && !chan_b && $stable(chan_b)) |=> cnt_up)
    else $error("A leading B did not count up");

endmodule : efol_quad_dec

// file: rtl/efol_glitch_filt.sv
/*
  Input filter: the output follows the input once it has held the same
  level for DEPTH+1 samples. Assumes input synchronous to pclk.
*/
module efol_glitch_filt #(
  parameter int unsigned DEPTH = 2
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);
  import efol_pkg::*;

  logic [DEPTH-1:0] hist;
  logic [DEPTH-1:0] next_hist;
  logic             next_dout;

  always_comb begin
    next_hist = {hist[DEPTH-2:0], din};
    next_dout = dout;
    if (hist == {DEPTH{din}}) begin
      next_dout = din;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist <= '0;
      dout <= 1'b0;
    end else begin
      hist <= next_hist;
      dout <= next_dout;
    end
  end

endmodule : efol_glitch_filt

// file: rtl/efol_fix_note.sv
/*
  Holds no logic and is kept empty on purpose.
  Assumes nothing of its surroundings.
*/

// file: verification/efol_enc_model.sv
/*
  Motor encoder model: one quadrature edge per step pulse, A leading B
  when dir is high.
  Assumes the bench spaces steps no closer than the maximum edge rate.
*/
module efol_enc_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic step,
  input  wire logic dir,
  output logic      chan_a,
  output logic      chan_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_q;
  // Gray sequence 00,10,11,01 gives A leading B when counting up
  assign chan_a = phase_q[0] ^ phase_q[1];
  assign chan_b = phase_q[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 2'h0;
    end else if (step) begin
      phase_q <= dir ? phase_q + 2'h1 : phase_q - 2'h1;
    end
  end
endmodule : efol_enc_model

// file: verification/test_efol_encoder_feedback.sv
/*
  Self-checking bench for the encoder feedback block over APB.
  Assumes the package efol_pkg and a small refresh interval.
*/
module test_efol_encoder_feedback;
  import efol_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, loop_position;
  logic [9:0]  sincos_phase;
  logic        enc_a, enc_b, step, dir, ax_a, ax_b, ax_i, net_variant;
  logic        unbuf_a, unbuf_b, regen_a, regen_b;
  int          num_errors, comparisons, cyc;

  efol_encoder_feedback #(.UPD_CYC(50)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .motor_enc_chan_a(enc_a),
    .motor_enc_chan_b(enc_b), .sincos_phase(sincos_phase),
    .aux_enc_chan_a(ax_a), .aux_enc_chan_b(ax_b), .aux_enc_index(ax_i),
    .net_variant(net_variant), .unbuf_chan_a(unbuf_a), .unbuf_chan_b(unbuf_b),
    .regen_out_chan_a(regen_a), .regen_out_chan_b(regen_b),
    .loop_position(loop_position)
  );
  efol_enc_model enc (
    .pclk(pclk), .presetn(presetn), .step(step), .dir(dir),
    .chan_a(enc_a), .chan_b(enc_b)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic conclude();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, q, exp);
    chk("pslverr", {31'h0, e}, 32'h0);
  endtask : rdc

  task automatic move(input int n, input logic d);
    repeat (n) begin
      step <= 1'b1;
      dir  <= d;
      @(posedge pclk);
      step <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask : move

  // Aux pin change held past the minimum pulse width
  task automatic aux(input logic a, input logic b);
    ax_a <= a;
    ax_b <= b;
    repeat (12) @(posedge pclk);
  endtask : aux

  initial begin
    logic [31:0] q;
    logic        e;
    {presetn, psel, penable, pwrite, step, dir, ax_a, ax_b, ax_i, net_variant} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sincos_phase = 10'h100;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", EFOL_ADDR_CTRL, 32'h0);
    rdc("interp", EFOL_ADDR_INTERP, 32'h2);
    rdc("div", EFOL_ADDR_DIV, 32'h0);
    wr(EFOL_ADDR_INTERP, 32'h1);
    rdc("interp", EFOL_ADDR_INTERP, 32'h2);
    wr(EFOL_ADDR_INTERP, 32'hF);
    rdc("interp", EFOL_ADDR_INTERP, 32'hA);
    move(9, 1'b1);
    rdc("mpos", EFOL_ADDR_MPOS, 32'h9);
    chk("unbuf", {30'h0, unbuf_a, unbuf_b}, {30'h0, enc_a, enc_b});
    chk("regen", {30'h0, regen_a, regen_b}, {30'h0, enc_a, enc_b});
    wr(EFOL_ADDR_CTRL, 32'h1);
    move(3, 1'b0);
    rdc("mpos", EFOL_ADDR_MPOS, 32'h6);
    repeat (4) @(posedge pclk);
    chk("regen", {30'h0, regen_a, regen_b}, {30'h0, enc_a, enc_b});
    wr(EFOL_ADDR_MPOS, 32'h55);
    rdc("mpos", EFOL_ADDR_MPOS, 32'h6);
    apb(1'b0, 8'h1C, 32'h0, q, e);
    chk("unmapped", q, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    wr(EFOL_ADDR_CTRL, 32'h4);
    wr(EFOL_ADDR_INTERP, 32'h3);
    repeat (4) @(posedge pclk);
    chk("loop", loop_position, 32'hA);
    wr(EFOL_ADDR_DIV, 32'h1);
    wr(EFOL_ADDR_CTRL, 32'h6);
    repeat (4) @(posedge pclk);
    chk("loop", loop_position, 32'hA);
    // Position 10 halved is 5: quadrature state a high, b low
    repeat (100) @(posedge pclk);
    chk("regen div", {30'h0, regen_a, regen_b}, 32'h2);
    wr(EFOL_ADDR_CTRL, 32'h2);
    rdc("stat", EFOL_ADDR_STAT, 32'h4);
    // Count 6 halved is 3: quadrature state a low, b high
    repeat (100) @(posedge pclk);
    chk("regen div", {30'h0, regen_a, regen_b}, 32'h1);
    wr(EFOL_ADDR_CTRL, 32'h0);
    aux(1'b1, 1'b0);
    aux(1'b1, 1'b1);
    aux(1'b0, 1'b1);
    aux(1'b0, 1'b0);
    rdc("apos", EFOL_ADDR_APOS, 32'h4);
    wr(EFOL_ADDR_CTRL, {27'h0, EFOL_AUX_CWCCW, 3'h0});
    aux(1'b1, 1'b0);
    aux(1'b0, 1'b0);
    rdc("apos", EFOL_ADDR_APOS, 32'h5);
    aux(1'b0, 1'b1);
    aux(1'b1, 1'b1);
    aux(1'b0, 1'b0);
    rdc("apos", EFOL_ADDR_APOS, 32'h4);
    aux(1'b1, 1'b0);
    aux(1'b1, 1'b1);
    aux(1'b0, 1'b0);
    rdc("apos", EFOL_ADDR_APOS, 32'h5);
    wr(EFOL_ADDR_CTRL, {27'h0, EFOL_AUX_STEPDIR, 3'h0});
    aux(1'b0, 1'b1);
    aux(1'b1, 1'b1);
    aux(1'b0, 1'b1);
    rdc("apos", EFOL_ADDR_APOS, 32'h6);
    aux(1'b0, 1'b0);
    aux(1'b1, 1'b0);
    rdc("apos", EFOL_ADDR_APOS, 32'h5);
    ax_i <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc("aidx", EFOL_ADDR_AIDX, 32'h5);
    net_variant <= 1'b1;
    wr(EFOL_ADDR_CTRL, 32'h2);
    rdc("stat", EFOL_ADDR_STAT, 32'h1);
    conclude();
  end
endmodule : test_efol_encoder_feedback
